//--- verif/lmu_regs_properties.sv
// Checker: port relations of the step-up and PWM routing register block
`timescale 1ns/1ps
`default_nettype none
module lmu_regs_properties
    import lmu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic ext_pwm_in,
    input wire lmu_drive_s drive_req,
    input wire lmu_drive_s led_drive,
    input wire logic [7:0] step_up_code,
    input wire logic [4:0] step_up_target_volts,
    input wire logic [2:0] safety_arm
);
    // --------------------
    // Assertions
    // --------------------
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Code and volts load in the same cycle; the guard keeps to settled codes
    a_reset_values: assert property ($rose(nrst) |-> step_up_code == LMU_RST_BOOST
        && safety_arm == 3'h0) else $error("outputs wrong at reset release");
    a_volts_in_range: assert property ($stable(step_up_code) && step_up_code >= 8'h08
        && step_up_code <= 8'h14 |-> step_up_target_volts == step_up_code[4:0])
        else $error("target volts differ from code");
    a_volts_low_clamp: assert property ($stable(step_up_code) && step_up_code < 8'h08
        |-> step_up_target_volts == 5'h08) else $error("low code not reported as 8 V");
    a_volts_high_clamp: assert property ($stable(step_up_code) && step_up_code > 8'h14
        |-> step_up_target_volts == 5'h14) else $error("high code not reported as 20 V");
    a_drive_needs_request: assert property ($past(nrst)
        |-> (led_drive & ~$past(drive_req)) == 5'h00) else $error("drive without request");
    a_pwm_high_passes: assert property ($past(nrst) && ext_pwm_in && $past(ext_pwm_in)
        && $past(ext_pwm_in, 2) && $past(ext_pwm_in, 3) |-> led_drive == $past(drive_req))
        else $error("drive gated while PWM high");
    a_pull_scl_low: assert property ($rose(sda_oe) |-> !$past(scl_in) && !scl_in)
        else $error("data line pulled while clock high");
    a_config_holds_idle: assert property ($past(scl_in, 3) && $past(scl_in, 2)
        && $past(scl_in) && scl_in |-> $stable(step_up_code) && $stable(safety_arm))
        else $error("config changed without bus clocking");
    a_sda_only_low: assert property (sda_out == 1'b0) else $error("data line driven high");

    // Main scenarios reached
    c_ack: cover property ($rose(sda_oe));
    c_gated: cover property ($past(drive_req) != 5'h00 && led_drive != $past(drive_req));
    c_top_code: cover property (step_up_target_volts == 5'h14);
endmodule

bind lmu_regs lmu_regs_properties u_lmu_regs_properties (.clk_sys(clk_sys), .nrst(nrst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .ext_pwm_in(ext_pwm_in), .drive_req(drive_req), .led_drive(led_drive),
    .step_up_code(step_up_code), .step_up_target_volts(step_up_target_volts),
    .safety_arm(safety_arm));
`default_nettype wire

//--- verif/tb_lmu_regs.sv
// Testbench: serial register access, step-up codes and external PWM gating
`timescale 1ns/1ps
`default_nettype none
module tb_lmu_regs;
    import lmu_pkg::*;
    // --------------------
    // Wiring
    // --------------------
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic scl = 1'b1;
    logic sda_drv = 1'b1;
    logic ext_pwm_in = 1'b0;
    lmu_drive_s drive_req = '0;
    logic sda_out, sda_oe, ack;
    lmu_drive_s led_drive;
    logic [7:0] step_up_code, rd;
    logic [4:0] step_up_target_volts;
    logic [2:0] safety_arm;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire logic sda_line = sda_drv & ~sda_oe; // Pulled-up open-drain wire

    always #2 clk_sys = ~clk_sys;

    lmu_regs u_lmu_regs (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .ext_pwm_in(ext_pwm_in), .drive_req(drive_req),
        .led_drive(led_drive), .step_up_code(step_up_code),
        .step_up_target_volts(step_up_target_volts), .safety_arm(safety_arm));

    // --------------------
    // Tasks
    // --------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Drive both lines just after an edge, then hold for n cycles
    task automatic put(input logic c, input logic d, input int n);
        scl = c;
        sda_drv = d;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            put(1'b0, b[i], 3);
            put(1'b1, b[i], 3);
        end
        put(1'b0, 1'b1, 3);
        put(1'b1, 1'b1, 1);
        ack = ~sda_line;
        put(1'b1, 1'b1, 2);
    endtask

    task automatic rbyte(input logic nack);
        for (int i = 7; i >= 0; i--) begin
            put(1'b0, 1'b1, 3);
            put(1'b1, 1'b1, 1);
            rd[i] = sda_line;
            put(1'b1, 1'b1, 2);
        end
        put(1'b0, nack, 3);
        put(1'b1, nack, 3);
    endtask

    // Start from either idle or a finished byte; stop always from clock low
    task automatic start();
        put(1'b0, 1'b1, 3);
        put(1'b1, 1'b1, 3);
        put(1'b1, 1'b0, 3);
    endtask

    task automatic stop();
        put(1'b0, 1'b0, 3);
        put(1'b1, 1'b0, 3);
        put(1'b1, 1'b1, 3);
    endtask

    task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
        start();
        wbyte({LMU_DEV_ADDR_DEFAULT, 1'b0});
        wbyte(ofs);
        wbyte(d);
        stop();
    endtask

    task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
        start();
        wbyte({LMU_DEV_ADDR_DEFAULT, 1'b0});
        wbyte(ofs);
        start();
        wbyte({LMU_DEV_ADDR_DEFAULT, 1'b1});
        rbyte(1'b1);
        stop();
        check($sformatf("reg %h", ofs), rd, exp);
    endtask

    // Hang guard, the whole run needs some 6600 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // --------------------
    // Tests
    // --------------------
    initial begin
        put(1'b1, 1'b1, 2);
        nrst = 1'b1;
        put(1'b1, 1'b1, 2);
        rchk(LMU_OFS_BOOST, 8'h08);
        rchk(LMU_OFS_PWM, 8'h00);
        check("code", step_up_code, 8'h08);
        check("arm", {5'h0, safety_arm}, 8'h00);
        $display("test reset values done");
        for (int c = 8; c <= 20; c++) begin
            wreg(LMU_OFS_BOOST, 8'(c));
            check("volts", {3'h0, step_up_target_volts}, 8'(c));
        end
        wreg(LMU_OFS_BOOST, 8'ha5);
        rchk(LMU_OFS_BOOST, 8'ha5);
        check("code", step_up_code, 8'ha5);
        check("volts", {3'h0, step_up_target_volts}, 8'h14);
        wreg(LMU_OFS_BOOST, 8'h03);
        check("volts", {3'h0, step_up_target_volts}, 8'h08);
        $display("test step-up codes done");
        wreg(LMU_OFS_PWM, 8'ha0);
        check("arm", {5'h0, safety_arm}, 8'h05);
        rchk(LMU_OFS_PWM, 8'ha0);
        wreg(LMU_OFS_PWM, 8'h5f);
        check("arm", {5'h0, safety_arm}, 8'h02);
        rchk(LMU_OFS_PWM, 8'h5f);
        // Read burst from the place below: master ACK must move on to the next register
        start();
        wbyte({LMU_DEV_ADDR_DEFAULT, 1'b0});
        wbyte(LMU_OFS_PWM - 8'h01);
        start();
        wbyte({LMU_DEV_ADDR_DEFAULT, 1'b1});
        rbyte(1'b0);
        check("burst first", rd, 8'h00);
        rbyte(1'b1);
        stop();
        check("burst second", rd, 8'h5f);
        // Unmapped place and a foreign device address are both ignored
        wreg(8'h30, 8'hff);
        rchk(8'h30, 8'h00);
        start();
        wbyte({~LMU_DEV_ADDR_DEFAULT, 1'b0});
        stop();
        check("foreign ack", {7'h0, ack}, 8'h00);
        $display("test enable register done");
        drive_req = 5'h1f;
        wreg(LMU_OFS_GPIO_CTRL, 8'hff);
        rchk(LMU_OFS_GPIO_CTRL, 8'h10);
        for (int i = 0; i < 5; i++) begin
            wreg(LMU_OFS_PWM, 8'(1 << i));
            ext_pwm_in = 1'b0;
            put(1'b1, 1'b1, 4);
            check("dimmed", {3'h0, led_drive}, 8'h1f & ~8'(1 << i));
            ext_pwm_in = 1'b1;
            put(1'b1, 1'b1, 4);
            check("lit", {3'h0, led_drive}, 8'h1f);
        end
        wreg(LMU_OFS_GPIO_CTRL, 8'h00);
        ext_pwm_in = 1'b0;
        put(1'b1, 1'b1, 4);
        check("pin off", {3'h0, led_drive}, 8'h1f);
        drive_req = 5'h00;
        put(1'b1, 1'b1, 4);
        check("no request", {3'h0, led_drive}, 8'h00);
        $display("test external dimming done");
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- verilog/lmu_pkg.sv
// Package: register map, field positions, reset values and shared types
package lmu_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] LMU_OFS_GPIO_CTRL = 8'h06;
    localparam logic [7:0] LMU_OFS_BOOST = 8'h0d;
    localparam logic [7:0] LMU_OFS_PWM = 8'h2b;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] LMU_RST_BOOST = 8'h08;
    localparam logic [7:0] LMU_RST_PWM = 8'h00;
    localparam logic LMU_RST_PIN_EN = 1'b0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LMU_BIT_PIN_EN = 4;
    localparam int LMU_BIT_SAFETY_R = 7;
    localparam int LMU_BIT_SAFETY_G = 6;
    localparam int LMU_BIT_SAFETY_B = 5;
    localparam int LMU_EXT_SEL_MSB = 4;
    localparam int LMU_EXT_SEL_LSB = 0;

    // ------------------------------------------------------------------
    // Step-up target range in volts, one volt per code step
    // ------------------------------------------------------------------
    localparam logic [7:0] LMU_BOOST_CODE_MIN = 8'h08;
    localparam logic [7:0] LMU_BOOST_CODE_MAX = 8'h14;

    // ------------------------------------------------------------------
    // Serial control port
    // ------------------------------------------------------------------
    localparam logic [6:0] LMU_DEV_ADDR_DEFAULT = 7'h2a; // Arbitrary value
    localparam logic [3:0] LMU_ACK_SLOT = 4'h8;
    localparam logic [3:0] LMU_LAST_BIT = 4'h7;

    // Serial control port states
    typedef enum logic [2:0] {
        LMU_ST_IDLE,
        LMU_ST_DEVADDR,
        LMU_ST_REGADDR,
        LMU_ST_WRDATA,
        LMU_ST_RDDATA
    } lmu_state_e;

    // One bit per driven output, order matches enable bits 4..0
    typedef struct packed {
        logic red_led_output;
        logic green_led_output;
        logic blue_led_output;
        logic primary_backlight;
        logic secondary_backlight;
    } lmu_drive_s;

endpackage

//--- verilog/lmu_regs.sv
// Step-up level and external PWM routing registers behind a two-wire serial port
//
// Behaviour
// - Step-up codes 8 to 20 select a target of 8 V to 20 V, one volt per code step.
// - The step-up register resets to code 8 with only bit 3 set and is fully read/write.
// - PWM enable bits 7, 6 and 5 arm the red, green and blue safety function when set.
// - PWM enable bits 4, 3 and 2 put red, green and blue under external PWM dimming when set.
// - PWM enable bits 1 and 0 put the primary and secondary backlight under external PWM.
// - The PWM enable register is fully read/write and resets to zero.
// - The external PWM pin is only honoured while bit 4 of the GPIO control register is set.
`timescale 1ns/1ps
`default_nettype none

module lmu_regs
    import lmu_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = LMU_DEV_ADDR_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic ext_pwm_in,
    input wire lmu_drive_s drive_req,
    output lmu_drive_s led_drive,
    output logic [7:0] step_up_code,
    output logic [4:0] step_up_target_volts,
    output logic [2:0] safety_arm
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] step_up_voltage_setting_reg;
    logic [7:0] pwm_source_and_safety_enables_reg;
    logic pin_enable_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    lmu_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] rd_shift_reg;
    logic [7:0] ptr_reg;
    logic ack_want_reg;
    logic pwm_meta_reg;
    logic pwm_level_reg;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic byte_done;
    logic [7:0] rx_byte;
    logic wr_strobe;

    // Register read decode, used for the first and every following read byte
    function automatic logic [7:0] reg_read(
        input logic [7:0] ofs,
        input logic [7:0] boost,
        input logic [7:0] pwm_en,
        input logic pin_en
    );
        logic [7:0] val;
        val = 8'h00;
        if (ofs == LMU_OFS_BOOST) begin
            val = boost;
        end else if (ofs == LMU_OFS_PWM) begin
            val = pwm_en;
        end else if (ofs == LMU_OFS_GPIO_CTRL) begin
            val[LMU_BIT_PIN_EN] = pin_en;
        end
        return val;
    endfunction

    // ------------------------------------------------------------------
    // Serial line edge and condition detection
    // ------------------------------------------------------------------
    // Lines are synchronous; one stage of history gives the edges
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
        end
    end

    assign scl_rise = scl_in & ~scl_q_reg;
    assign scl_fall = ~scl_in & scl_q_reg;
    assign start_cond = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    assign stop_cond = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
    assign byte_done = scl_rise && (state_reg != LMU_ST_IDLE) && (bit_cnt_reg == LMU_LAST_BIT);
    assign rx_byte = {shift_reg[6:0], sda_in};
    assign wr_strobe = byte_done && (state_reg == LMU_ST_WRDATA);
    assign sda_out = 1'b0; // Open drain: only ever pulls low

    // ------------------------------------------------------------------
    // Serial protocol sequencer
    // ------------------------------------------------------------------
    // A start always restarts the sequence, which also serves repeated start
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= LMU_ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ack_want_reg <= 1'b0;
        end else if (start_cond) begin
            state_reg <= LMU_ST_DEVADDR;
            bit_cnt_reg <= 4'h0;
            ack_want_reg <= 1'b0;
        end else if (stop_cond) begin
            state_reg <= LMU_ST_IDLE;
            bit_cnt_reg <= 4'h0;
        end else if (scl_rise && state_reg != LMU_ST_IDLE) begin
            if (bit_cnt_reg == LMU_ACK_SLOT) begin
                bit_cnt_reg <= 4'h0;
                // Master NACK ends a read burst
                if (state_reg == LMU_ST_RDDATA && !ack_want_reg && sda_in) begin
                    state_reg <= LMU_ST_IDLE;
                end
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg <= rx_byte;
                if (bit_cnt_reg == LMU_LAST_BIT) begin
                    unique case (state_reg)
                        LMU_ST_DEVADDR: begin
                            ack_want_reg <= (rx_byte[7:1] == DEV_ADDR);
                            if (rx_byte[7:1] != DEV_ADDR) begin
                                state_reg <= LMU_ST_IDLE;
                            end else if (rx_byte[0]) begin
                                state_reg <= LMU_ST_RDDATA;
                            end else begin
                                state_reg <= LMU_ST_REGADDR;
                            end
                        end
                        LMU_ST_REGADDR: begin
                            ack_want_reg <= 1'b1;
                            state_reg <= LMU_ST_WRDATA;
                        end
                        LMU_ST_WRDATA: begin
                            ack_want_reg <= 1'b1;
                        end
                        LMU_ST_RDDATA: begin
                            ack_want_reg <= 1'b0; // Master owns this slot
                        end
                        LMU_ST_IDLE: begin
                            ack_want_reg <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // Register pointer and read data, advancing after every byte moved
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ptr_reg <= 8'h00;
            rd_shift_reg <= 8'h00;
        end else if (byte_done && state_reg == LMU_ST_REGADDR) begin
            ptr_reg <= rx_byte;
        end else if (wr_strobe) begin
            ptr_reg <= ptr_reg + 8'h01;
        end else if (byte_done && state_reg == LMU_ST_DEVADDR && rx_byte[0]) begin
            rd_shift_reg <= reg_read(ptr_reg, step_up_voltage_setting_reg,
                                     pwm_source_and_safety_enables_reg, pin_enable_reg);
            ptr_reg <= ptr_reg + 8'h01;
        end else if (scl_rise && state_reg == LMU_ST_RDDATA && bit_cnt_reg == LMU_ACK_SLOT
                     && !ack_want_reg && !sda_in) begin
            rd_shift_reg <= reg_read(ptr_reg, step_up_voltage_setting_reg,
                                     pwm_source_and_safety_enables_reg, pin_enable_reg);
            ptr_reg <= ptr_reg + 8'h01;
        end
    end

    // Data line drive, changed only as the clock falls and held through clock high; start, stop and idle release it at once
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sda_oe <= 1'b0;
        end else if (start_cond || stop_cond || state_reg == LMU_ST_IDLE) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            if (bit_cnt_reg == LMU_ACK_SLOT) begin
                sda_oe <= ack_want_reg;
            end else if (state_reg == LMU_ST_RDDATA) begin
                sda_oe <= ~rd_shift_reg[3'(LMU_LAST_BIT - bit_cnt_reg)];
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Step-up level, fully writable
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            step_up_voltage_setting_reg <= LMU_RST_BOOST;
        end else if (wr_strobe && ptr_reg == LMU_OFS_BOOST) begin
            step_up_voltage_setting_reg <= rx_byte;
        end
    end

    // Safety arm and external PWM routing, all off after reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pwm_source_and_safety_enables_reg <= LMU_RST_PWM;
        end else if (wr_strobe && ptr_reg == LMU_OFS_PWM) begin
            pwm_source_and_safety_enables_reg <= rx_byte;
        end
    end

    // Pin enable; other bits of this register live elsewhere and read zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_enable_reg <= LMU_RST_PIN_EN;
        end else if (wr_strobe && ptr_reg == LMU_OFS_GPIO_CTRL) begin
            pin_enable_reg <= rx_byte[LMU_BIT_PIN_EN];
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Two stages on the PWM pin, which may come from an unrelated source
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pwm_meta_reg <= 1'b0;
            pwm_level_reg <= 1'b0;
        end else begin
            pwm_meta_reg <= ext_pwm_in;
            pwm_level_reg <= pwm_meta_reg;
        end
    end

    // Gate each selected output with the PWM level; a disabled pin never dims
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            led_drive <= '0;
        end else begin
            led_drive <= drive_req & ~(pwm_source_and_safety_enables_reg[LMU_EXT_SEL_MSB:
                LMU_EXT_SEL_LSB] & {5{pin_enable_reg}} & {5{~pwm_level_reg}});
        end
    end

    // Step-up target; codes outside the table clamp to the nearest end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            step_up_code <= LMU_RST_BOOST;
            step_up_target_volts <= LMU_RST_BOOST[4:0];
            safety_arm <= 3'h0;
        end else begin
            step_up_code <= step_up_voltage_setting_reg;
            if (step_up_voltage_setting_reg < LMU_BOOST_CODE_MIN) begin
                step_up_target_volts <= LMU_BOOST_CODE_MIN[4:0];
            end else if (step_up_voltage_setting_reg > LMU_BOOST_CODE_MAX) begin
                step_up_target_volts <= LMU_BOOST_CODE_MAX[4:0];
            end else begin
                step_up_target_volts <= step_up_voltage_setting_reg[4:0];
            end
            safety_arm <= {pwm_source_and_safety_enables_reg[LMU_BIT_SAFETY_R],
                           pwm_source_and_safety_enables_reg[LMU_BIT_SAFETY_G],
                           pwm_source_and_safety_enables_reg[LMU_BIT_SAFETY_B]};
        end
    end

endmodule

`default_nettype wire
